// File: design/adapter_selftest_sequencer.sv
// Power-up self-test sequencer with result word, microcode load and revision words
`timescale 1ns/1ns
`default_nettype none
`include "selftest_regs.svh"
module adapter_selftest_sequencer (
    input wire logic clk_i, // 250 MHz clock
    input wire logic sys_rst_i, // Synchronous reset, high
    input wire logic host_rd_i, // Host read strobe
    input wire logic [12:0] host_addr_i, // Node byte offset
    output logic [31:0] host_rdata_o, // Read data
    output logic host_rvalid_o, // Read data valid
    input wire logic bif_pass_i, // Interface self-test passed pin
    output logic [15:0] loop_tx_o, // Loopback data out
    output logic loop_tx_valid_o, // Loopback data valid
    input wire logic [15:0] loop_rx_i, // Loopback data back (pin)
    output logic bp_req_o, // Backplane access request
    output logic bp_we_o, // Backplane write
    output logic [12:0] bp_addr_o, // Backplane node offset
    output logic [31:0] bp_wdata_o, // Backplane write data
    input wire logic bp_ack_i, // Backplane access done
    input wire logic [31:0] bp_rdata_i, // Backplane read data
    output logic [3:0] nv_addr_o, // Boot image word index
    input wire logic [31:0] nv_data_i, // Boot image word
    output logic st_busy_o, // Self-test or load running
    output logic st_pass_o, // Passed and code loaded
    output logic st_fail_o // Self-test failed
);
    selftest_pkg::seq_state_e state_q;
    logic [3:0] test_q;
    logic [11:0] fail_q;
    logic phase_q;
    logic [5:0] idx_q;
    logic [2:0] wait_q;
    logic loaded_q, rd_got_q;
    logic [31:0] func_rev_q, boot_rev_q;
    logic [15:0] scratch_q [0:31];
    logic [31:0] cstore_q [0:15];
    logic [15:0] pbuf_q [0:63];
    logic [15:0] ls_q [0:1023];
    logic [3:0] flags_q [0:3];
    logic [15:0] internal_peripheral_bus_q [0:7];
    logic [15:0] toggle_q;
    logic [3:0] port_maint_ctrl_status_q;
    logic [15:0] bp_data_q;
    logic pass_s1_q, pass_s2_q;
    logic [15:0] rx_s1_q, rx_s2_q;
    logic [15:0] pat;
    logic [5:0] last_idx;
    logic [9:0] ls_addr;
    logic [16:0] sum;
    logic [3:0] exp_flags;
    logic [15:0] vec_a;
    logic check_ok;
    logic stall;
    logic running;
    logic write_ph;
    logic read_ph;
    logic [11:0] fail_d;
    logic [15:0] result_word;

    // Pattern tied to the entry so an address fault shows as a data fault
    assign pat = {`PAT_SEED ^ {2'b00, idx_q}, 2'b00, idx_q};
    assign ls_addr = {test_q, idx_q};
    assign result_word = {test_q, fail_q};
    assign running = (state_q == selftest_pkg::ST_RUN);
    assign write_ph = running && !phase_q;
    assign read_ph = running && phase_q;
    assign fail_d = fail_q + {6'h00, idx_q} + 12'h001;

    // Entries per test, last index of each
    always_comb begin
        case (test_q)
            4'h1: last_idx = 6'h03;
            4'h2: last_idx = 6'h1F;
            4'h3: last_idx = 6'h0F;
            4'h4: last_idx = 6'h3F;
            4'h7, 4'h8, 4'hB: last_idx = 6'h07;
            4'h9: last_idx = 6'h0F;
            4'hA: last_idx = 6'h03;
            default: last_idx = 6'h00;
        endcase
    end

    // Flag vectors: zero, signed overflow to negative, carry out, both
    always_comb begin
        case (idx_q[1:0])
            2'd0: begin
                vec_a = 16'h0000;
                exp_flags = 4'b1000;
            end
            2'd1: begin
                vec_a = 16'h7FFF;
                exp_flags = 4'b0110;
            end
            2'd2: begin
                vec_a = 16'hFFFF;
                exp_flags = 4'b1001;
            end
            default: begin
                vec_a = 16'h8000;
                exp_flags = 4'b1011;
            end
        endcase
    end
    // Second operand equals first except vector 1 and 2 add one
    assign sum = {1'b0, vec_a} + ((idx_q[1:0] == 2'd1 || idx_q[1:0] == 2'd2) ?
        17'h0_0001 : {1'b0, vec_a});

    // Read-phase comparison per test
    always_comb begin
        case (test_q)
            4'h1: check_ok = (flags_q[idx_q[1:0]] == exp_flags);
            4'h2: check_ok = (scratch_q[idx_q[4:0]] == pat);
            4'h3: check_ok = (cstore_q[idx_q[3:0]] == {ls_q[ls_addr], pat});
            4'h4: check_ok = (pbuf_q[idx_q] == pat);
            4'h5: check_ok = (rx_s2_q == pat);
            4'h6: check_ok = pass_s2_q;
            4'h7: check_ok = (ls_q[ls_addr] == pat);
            4'h8: check_ok = (ls_q[ls_addr] == ~pat);
            4'h9: check_ok = toggle_q[idx_q[3:0]];
            4'hA: check_ok = port_maint_ctrl_status_q[idx_q[1:0]];
            4'hB: check_ok = (internal_peripheral_bus_q[idx_q[2:0]] == pat);
            4'hC: check_ok = (bp_data_q == pat);
            default: check_ok = 1'b0;
        endcase
    end

    // Engine holds while the loopback settles or the backplane is busy
    assign stall = (read_ph && test_q == 4'h5 && wait_q != 3'h0) ||
        (running && test_q == 4'hC && (!bp_ack_i || (phase_q && !rd_got_q)));

    // Pins cross into the clock domain through two flops
    always_ff @(posedge clk_i) begin
        pass_s1_q <= bif_pass_i;
        pass_s2_q <= pass_s1_q;
        rx_s1_q <= loop_rx_i;
        rx_s2_q <= rx_s1_q;
    end

    // Sequencer: walks tests 1..C, then loads the control store
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= selftest_pkg::ST_RUN;
            test_q <= `TEST_FIRST;
            fail_q <= `FAIL_ZERO;
            phase_q <= 1'b0;
            idx_q <= 6'h00;
            loaded_q <= 1'b0;
        end else begin
            case (state_q)
                selftest_pkg::ST_RUN: begin
                    if (!stall) begin
                        if (read_ph && !check_ok) begin
                            fail_q <= fail_d;
                            state_q <= selftest_pkg::ST_FAIL;
                        end else if (idx_q != last_idx) begin
                            idx_q <= idx_q + 6'h01;
                        end else if (!phase_q) begin
                            idx_q <= 6'h00;
                            phase_q <= 1'b1;
                        end else if (test_q == `TEST_LAST) begin
                            idx_q <= 6'h00;
                            state_q <= selftest_pkg::ST_LOAD;
                        end else begin
                            test_q <= test_q + 4'h1;
                            fail_q <= `FAIL_ZERO;
                            phase_q <= 1'b0;
                            idx_q <= 6'h00;
                        end
                    end
                end
                selftest_pkg::ST_LOAD: begin
                    if (idx_q[3:0] == `CS_LAST) begin
                        state_q <= selftest_pkg::ST_DONE;
                        loaded_q <= 1'b1;
                    end else begin
                        idx_q <= idx_q + 6'h01;
                    end
                end
                selftest_pkg::ST_DONE, selftest_pkg::ST_FAIL: state_q <= state_q;
                default: state_q <= selftest_pkg::ST_FAIL;
            endcase
        end
    end

    // Loopback settle counter covers the two-flop return path
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wait_q <= `LOOP_WAIT;
        end else if (write_ph) begin
            wait_q <= `LOOP_WAIT;
        end else if (read_ph && wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end
    end

    // Test 1 flag capture from the adder
    always_ff @(posedge clk_i) begin
        if (write_ph && test_q == 4'h1) begin
            flags_q[idx_q[1:0]][`FLAG_Z] <= (sum[15:0] == 16'h0000);
            flags_q[idx_q[1:0]][`FLAG_N] <= sum[15];
            flags_q[idx_q[1:0]][`FLAG_V] <= (sum[15] != vec_a[15]) &&
                idx_q[1:0] != 2'd2;
            flags_q[idx_q[1:0]][`FLAG_C] <= sum[16];
        end
    end

    // Scratch RAM, packet buffers and peripheral registers fills
    always_ff @(posedge clk_i) begin
        if (write_ph && test_q == 4'h2) begin
            scratch_q[idx_q[4:0]] <= pat;
        end
        if (write_ph && test_q == 4'h4) begin
            pbuf_q[idx_q] <= pat;
        end
        if (write_ph && test_q == 4'hB) begin
            internal_peripheral_bus_q[idx_q[2:0]] <= pat;
        end
    end

    // Control store: written by test 3, then by the microcode load
    always_ff @(posedge clk_i) begin
        if (write_ph && test_q == 4'h3) begin
            cstore_q[idx_q[3:0]] <= {pat, pat};
        end else if (state_q == selftest_pkg::ST_LOAD) begin
            cstore_q[idx_q[3:0]] <= nv_data_i;
        end
    end

    // Local store; a failure parks the result word at the top location
    always_ff @(posedge clk_i) begin
        if (read_ph && !stall && !check_ok) begin
            ls_q[`LS_RESULT] <= {test_q, fail_d};
        end else if (write_ph && (test_q == 4'h3 || test_q == 4'h7)) begin
            ls_q[ls_addr] <= pat;
        end else if (write_ph && test_q == 4'h8) begin
            ls_q[ls_addr] <= ~pat;
        end
    end

    // Toggle register set one bit at a time, cleared after each check
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            toggle_q <= 16'h0000;
        end else if (write_ph && test_q == 4'h9) begin
            toggle_q[idx_q[3:0]] <= 1'b1;
        end else if (read_ph && test_q == 4'h9) begin
            toggle_q[idx_q[3:0]] <= 1'b0;
        end
    end

    // Parity error bits injected, checked, then cleared
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            port_maint_ctrl_status_q <= 4'h0;
        end else if (write_ph && test_q == 4'hA) begin
            port_maint_ctrl_status_q[idx_q[1:0]] <= 1'b1;
        end else if (read_ph && test_q == 4'hA) begin
            port_maint_ctrl_status_q[idx_q[1:0]] <= 1'b0;
        end
    end

    // Revision words captured as the image streams in
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            func_rev_q <= 32'h0000_0000;
            boot_rev_q <= 32'h0000_0000;
        end else if (state_q == selftest_pkg::ST_LOAD) begin
            if (idx_q[3:0] == `FREV_IDX) begin
                func_rev_q <= nv_data_i;
            end
            if (idx_q[3:0] == `BREV_IDX) begin
                boot_rev_q <= nv_data_i;
            end
        end
    end

    // Read data caught at the first read ack; the compare waits for the next
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bp_data_q <= 16'h0000;
            rd_got_q <= 1'b0;
        end else if (read_ph && test_q == 4'hC && bp_ack_i && !rd_got_q) begin
            bp_data_q <= bp_rdata_i[15:0];
            rd_got_q <= 1'b1;
        end
    end

    // Outward drives; request held level for the whole of test C, through every ack
    assign bp_req_o = running && test_q == 4'hC;
    assign bp_we_o = write_ph;
    assign bp_addr_o = `OFF_QUEUE_BASE;
    assign bp_wdata_o = {16'h0000, pat};
    assign loop_tx_o = pat;
    assign loop_tx_valid_o = write_ph && test_q == 4'h5;
    assign nv_addr_o = idx_q[3:0];
    assign st_busy_o = running || state_q == selftest_pkg::ST_LOAD;
    assign st_pass_o = loaded_q;
    assign st_fail_o = (state_q == selftest_pkg::ST_FAIL);

    // Host read port; revisions read zero until the code is loaded
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            host_rdata_o <= 32'h0000_0000;
            host_rvalid_o <= 1'b0;
        end else begin
            host_rvalid_o <= host_rd_i;
            if (host_rd_i) begin
                case (host_addr_i)
                    `OFF_RESULT: host_rdata_o <= {16'h0000,
                        st_fail_o ? ls_q[`LS_RESULT] : result_word};
                    `OFF_FUNC_REV: host_rdata_o <= loaded_q ? func_rev_q : 32'h0000_0000;
                    `OFF_BOOT_REV: host_rdata_o <= loaded_q ? boot_rev_q : 32'h0000_0000;
                    default: host_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: design/selftest_pkg.sv
// Types shared by the self-test sequencer
package selftest_pkg;
    typedef enum logic [2:0] {ST_RUN, ST_LOAD, ST_DONE, ST_FAIL} seq_state_e;
    typedef logic [15:0] word_t;
endpackage

// File: design/selftest_regs.svh
// Offsets, field positions, reset values and timing counts of the self-test sequencer
`ifndef SELFTEST_REGS_SVH
`define SELFTEST_REGS_SVH
`define OFF_FUNC_REV 13'h108C
`define OFF_BOOT_REV 13'h1090
`define OFF_RESULT 13'h1FFC
`define OFF_QUEUE_BASE 13'h00F0
`define LS_RESULT 10'h3FF
`define RESULT_T1 16'h1000
`define TEST_FIRST 4'h1
`define TEST_LAST 4'hC
`define FAIL_ZERO 12'h000
`define CS_LAST 4'hF
`define FREV_IDX 4'h1
`define BREV_IDX 4'h2
`define LOOP_WAIT 3'h4
`define PAT_SEED 8'hA5
`define FLAG_Z 3
`define FLAG_N 2
`define FLAG_V 1
`define FLAG_C 0
`endif

// File: verif/adapter_selftest_sequencer_tb.sv
// Self-checking bench for the adapter self-test sequencer
`timescale 1ns/1ns
`default_nettype none
`include "selftest_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adapter_selftest_sequencer_tb;
    localparam logic [15:0] REV_TAG = 16'h4b2d; // Arbitrary revision tag
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic host_rd_i = 1'b0;
    logic [12:0] host_addr_i = 13'h0000;
    logic bif_pass_i = 1'b1;
    logic bad_rd = 1'b0;
    logic bad_loop = 1'b0;
    logic [1:0] delay = 2'h0;
    logic [31:0] host_rdata_o, bp_wdata_o, bp_rdata_i, nv_data_i, got_exp;
    logic [15:0] loop_tx_o, loop_rx_i;
    logic [12:0] bp_addr_o;
    logic [3:0] nv_addr_o;
    logic host_rvalid_o, loop_tx_valid_o, bp_req_o, bp_we_o, bp_ack_i;
    logic st_busy_o, st_pass_o, st_fail_o;
    logic [31:0] exp_q[$];
    int errors = 0;
    int total_checks = 0;
    adapter_selftest_sequencer dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .host_rd_i(host_rd_i), .host_addr_i(host_addr_i), .host_rdata_o(host_rdata_o),
        .host_rvalid_o(host_rvalid_o), .bif_pass_i(bif_pass_i), .loop_tx_o(loop_tx_o),
        .loop_tx_valid_o(loop_tx_valid_o), .loop_rx_i(loop_rx_i), .bp_req_o(bp_req_o),
        .bp_we_o(bp_we_o), .bp_addr_o(bp_addr_o), .bp_wdata_o(bp_wdata_o),
        .bp_ack_i(bp_ack_i), .bp_rdata_i(bp_rdata_i), .nv_addr_o(nv_addr_o),
        .nv_data_i(nv_data_i), .st_busy_o(st_busy_o), .st_pass_o(st_pass_o),
        .st_fail_o(st_fail_o));
    far_side_model #(.REV_TAG(REV_TAG)) far_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .delay_i(delay), .bad_rd_i(bad_rd), .bad_loop_i(bad_loop), .bp_req_i(bp_req_o),
        .bp_we_i(bp_we_o), .bp_wdata_i(bp_wdata_o), .bp_ack_o(bp_ack_i),
        .bp_rdata_o(bp_rdata_i), .loop_tx_i(loop_tx_o), .loop_tx_valid_i(loop_tx_valid_o),
        .loop_rx_o(loop_rx_i), .nv_addr_i(nv_addr_o), .nv_data_o(nv_data_i));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // One host read; the expected word waits in the queue
    task automatic rd(input logic [12:0] a, input logic [31:0] e);
        @(negedge clk_i);
        host_rd_i = 1'b1;
        host_addr_i = a;
        exp_q.push_back(e);
        @(negedge clk_i);
        host_rd_i = 1'b0;
    endtask
    // Reset, let the tests run, then read the outcome
    task automatic run(input logic bif, input logic bl, input logic br, input logic [15:0] res);
        logic ok;
        ok = (res[11:0] == 12'h000);
        @(negedge clk_i);
        sys_rst_i = 1'b1;
        bif_pass_i = bif;
        bad_loop = bl;
        bad_rd = br;
        delay = 2'($urandom);
        repeat (3) @(negedge clk_i);
        sys_rst_i = 1'b0;
        rd(`OFF_RESULT, 32'h0000_1000);
        rd(`OFF_FUNC_REV, 32'h0000_0000);
        for (int i = 0; i < 4000 && st_pass_o !== 1'b1 && st_fail_o !== 1'b1; i++) begin
            @(negedge clk_i);
        end
        `CHK(st_pass_o, ok)
        `CHK(st_fail_o, !ok)
        `CHK(st_busy_o, 1'b0)
        rd(`OFF_RESULT, {16'h0000, res});
        rd(`OFF_FUNC_REV, ok ? {REV_TAG, 12'h000, `FREV_IDX} : 32'h0000_0000);
        rd(`OFF_BOOT_REV, ok ? {REV_TAG, 12'h000, `BREV_IDX} : 32'h0000_0000);
        rd(13'h0400 | (13'($urandom) & 13'h03fc), 32'h0000_0000);
    endtask
    task automatic end_of_test();
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Each read answer is held against the oldest note
    always @(negedge clk_i) begin
        if (host_rvalid_o === 1'b1) begin
            got_exp = exp_q.pop_front();
            `CHK(host_rdata_o, got_exp)
        end
    end
    initial begin
        void'($urandom(32'h7d6b));
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        // Early tests run, then the next reset lands in mid-run
        repeat (60) @(negedge clk_i);
        run(1'b1, 1'b0, 1'b0, 16'hc000);
        run(1'b1, 1'b1, 1'b0, 16'h5001);
        run(1'b0, 1'b0, 1'b0, 16'h6001);
        run(1'b1, 1'b0, 1'b1, 16'hc001);
        repeat (4) @(negedge clk_i);
        `CHK(exp_q.size(), 0)
        end_of_test();
    end
    // Hang guard, far beyond the expected run length
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
endmodule
`default_nettype wire

// File: verif/far_side_model.sv
// Far side model: backplane responder, loopback path and boot image
`timescale 1ns/1ns
`default_nettype none
module far_side_model #(
    parameter logic [15:0] REV_TAG = 16'h4b2d // Arbitrary revision tag
) (
    input wire logic clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic [1:0] delay_i, // Extra ack wait
    input wire logic bad_rd_i, // Corrupt readback
    input wire logic bad_loop_i, // Corrupt loopback
    input wire logic bp_req_i, // Bus request
    input wire logic bp_we_i, // Bus write
    input wire logic [31:0] bp_wdata_i, // Bus write data
    output logic bp_ack_o, // Bus done
    output logic [31:0] bp_rdata_o, // Bus read data
    input wire logic [15:0] loop_tx_i, // Loop data out
    input wire logic loop_tx_valid_i, // Loop valid
    output logic [15:0] loop_rx_o, // Loop data back
    input wire logic [3:0] nv_addr_i, // Image index
    output logic [31:0] nv_data_o // Image word
);
    logic [31:0] base_q;
    logic [15:0] loop_q;
    logic [1:0] wait_q;
    // Ack after a variable wait, one pulse per wait, repeating while the request is held
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !bp_req_i || bp_ack_o) begin
            wait_q <= 2'h0;
            bp_ack_o <= 1'b0;
        end else if (wait_q == delay_i) begin
            bp_ack_o <= 1'b1;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end
    // Queue block base register and returned loop word
    always_ff @(posedge clk_i) begin
        if (bp_req_i && bp_ack_o && bp_we_i) begin
            base_q <= bp_wdata_i;
        end
        if (sys_rst_i) begin
            loop_q <= 16'hffff;
        end else if (loop_tx_valid_i) begin
            loop_q <= loop_tx_i;
        end
    end
    // Released bus shows inverted data, so a stale value never matches
    assign bp_rdata_o = (bp_ack_o && !bp_we_i) ? (base_q ^ {32{bad_rd_i}}) : ~base_q;
    assign loop_rx_o = loop_q ^ {16{bad_loop_i}};
    assign nv_data_o = {REV_TAG, 12'h000, nv_addr_i};
endmodule
`default_nettype wire

// File: verif/selftest_chk_asserts.sv
// Port checker for the self-test sequencer
`timescale 1ns/1ns
`default_nettype none
`include "selftest_regs.svh"
module selftest_chk (
    input wire logic clk_i, // Clock
    input wire logic sys_rst_i, // Reset
    input wire logic host_rd_i, // Read strobe
    input wire logic [12:0] host_addr_i, // Read offset
    input wire logic [31:0] host_rdata_o, // Read data
    input wire logic host_rvalid_o, // Read valid
    input wire logic loop_tx_valid_o, // Loop valid
    input wire logic bp_req_o, // Bus request
    input wire logic bp_we_o, // Bus write
    input wire logic [12:0] bp_addr_o, // Bus offset
    input wire logic bp_ack_i, // Bus done
    input wire logic st_busy_o, // Running
    input wire logic st_pass_o, // Passed
    input wire logic st_fail_o // Failed
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Host reads answered exactly one cycle later
    rd_answer_a: assert property (host_rd_i |=> host_rvalid_o)
        else $error("read not answered");
    stray_valid_a: assert property (!host_rd_i |=> !host_rvalid_o)
        else $error("read valid without strobe");
    // Function revision word stays hidden until code is loaded
    rev_hidden_a: assert property (host_rd_i && !st_pass_o
        && host_addr_i == `OFF_FUNC_REV |=> host_rdata_o == 32'h0000_0000)
        else $error("revision visible early");
    fail_code_a: assert property (host_rd_i && st_fail_o && host_addr_i == `OFF_RESULT
        |=> host_rdata_o[11:0] != 12'h000) else $error("failure code zero");
    pass_result_a: assert property (host_rd_i && st_pass_o
        && host_addr_i == `OFF_RESULT |=> host_rdata_o[15:0] == 16'hc000)
        else $error("pass result not last test");
    fail_sticky_a: assert property (st_fail_o |=> st_fail_o)
        else $error("failure flag dropped");
    one_outcome_a: assert property (!(st_pass_o && st_fail_o))
        else $error("pass and fail together");
    pass_idle_a: assert property (st_pass_o |-> !st_busy_o)
        else $error("busy after pass");
    loop_pulse_a: assert property (loop_tx_valid_o |=> !loop_tx_valid_o)
        else $error("loop valid longer than one cycle");
    bp_hold_a: assert property (bp_req_o && !bp_ack_i |=> bp_req_o && $stable(bp_we_o))
        else $error("bus request not held");
    bp_target_a: assert property (bp_req_o |-> bp_addr_o == 13'h00f0)
        else $error("bus request to wrong offset");
    // Main outcomes and a completed backplane write reached
    pass_seen_c: cover property ($rose(st_pass_o));
    fail_seen_c: cover property ($rose(st_fail_o));
    bp_write_c: cover property (bp_req_o && bp_we_o && bp_ack_i);
endmodule
bind adapter_selftest_sequencer selftest_chk chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .host_rd_i(host_rd_i), .host_addr_i(host_addr_i), .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o), .loop_tx_valid_o(loop_tx_valid_o), .bp_req_o(bp_req_o),
    .bp_we_o(bp_we_o), .bp_addr_o(bp_addr_o), .bp_ack_i(bp_ack_i), .st_busy_o(st_busy_o),
    .st_pass_o(st_pass_o), .st_fail_o(st_fail_o));
`default_nettype wire
